// ---- rtl/rsx_exec.sv ----
// Functional notes
// RQ1: taken return pops stack, program counter becomes popped entry plus one.
// RQ2: conditional return taken on carry set/clear or zero set/clear; plain always.
// RQ3: untaken return keeps stack and steps program counter by one.
// RQ4: subroutine return never alters carry or zero.
// RQ5: interrupt exit always pops stack straight into program counter.
// RQ6: interrupt exit restores carry and zero from saved copies.
// RQ7: interrupt exit enable form sets interrupt enable, disable form clears.
// RQ8: rotate left: bit 7 to carry and bit 0; zero from result.
// RQ9: rotate right: bit 0 to carry and bit 7; zero from result.
// RQ10: shift left: bit 7 to carry; fill 0, 1, old bit 0 or carry.
// RQ11: one-filling shift left always clears zero.
// RQ12: shift right: bit 0 to carry; fill 0, 1, old bit 7 or carry.
// RQ13: one-filling shift right always clears zero.
// RQ14: store writes register into 64-byte scratchpad, address register or immediate.
// RQ15: store address uses only low six bits.
// RQ16: subtract operand from register or immediate, result to first register.
// RQ17: subtract ignores carry in, result modulo 256.
// RQ18: subtract sets carry on borrow, clears otherwise.
// RQ19: subtract sets zero only when difference is zero.
// RQ20: call stack circular, pointer reset, underflow wraps.
// RQ21: rotate, shift, store, subtract step program counter; store keeps flags.
// RQ22: flags updated are seen by the very next return test.
`timescale 1ns/1ps
`include "rsx_cfg.svh"

module rsx_exec (
	input  wire logic                          CORE_CLK,
	input  wire logic                          RST,
	input  wire logic                          EXEC_VALID,
	input  wire rsx_pkg::rsx_op_t              EXEC_OP,
	input  wire rsx_pkg::rsx_cond_t            RETURN_COND,
	input  wire logic                          ISR_EXIT_ENABLE,
	input  wire logic [`RSX_REG_SEL_W-1:0]     DEST_REG,
	input  wire logic [`RSX_REG_SEL_W-1:0]     SOURCE_REG,
	input  wire logic [`RSX_DATA_W-1:0]        IMMEDIATE_BYTE,
	input  wire logic                          USE_IMMEDIATE,
	input  wire logic [`RSX_PC_W-1:0]          CALL_TARGET,
	input  wire logic                          ISR_SAVED_CARRY,
	input  wire logic                          ISR_SAVED_ZERO,
	input  wire logic                          REG_WR_EN,
	input  wire logic [`RSX_REG_SEL_W-1:0]     REG_WR_SEL,
	input  wire logic [`RSX_DATA_W-1:0]        REG_WR_DATA,
	input  wire logic [`RSX_REG_SEL_W-1:0]     REG_RD_SEL,
	input  wire logic [`RSX_SPAD_AW-1:0]       SPAD_RD_ADDR,
	output logic      [`RSX_PC_W-1:0]          PC,
	output logic                               CARRY_FLAG,
	output logic                               ZERO_FLAG,
	output logic                               INT_ENABLE,
	output logic      [`RSX_STACK_AW-1:0]      STACK_PTR,
	output logic      [`RSX_DATA_W-1:0]        REG_RD_DATA,
	output logic      [`RSX_DATA_W-1:0]        SPAD_RD_DATA
);
	import rsx_pkg::*;

	logic [`RSX_DATA_W-1:0]   regs_reg [`RSX_NUM_REGS];
	logic [`RSX_DATA_W-1:0]   spad_reg [`RSX_SPAD_DEPTH];
	logic [`RSX_PC_W-1:0]     stack_reg [`RSX_STACK_DEPTH];
	logic [`RSX_PC_W-1:0]     pc_reg;
	logic [`RSX_PC_W-1:0]     pc_next;
	logic [`RSX_STACK_AW-1:0] sp_reg;
	logic [`RSX_STACK_AW-1:0] sp_next;
	logic [`RSX_STACK_AW-1:0] sp_dec;
	logic [`RSX_STACK_AW-1:0] sp_inc;
	logic                     carry_reg;
	logic                     carry_next;
	logic                     zero_reg;
	logic                     zero_next;
	logic                     ie_reg;
	logic [`RSX_DATA_W-1:0]   dest_val;
	logic [`RSX_DATA_W-1:0]   operand;
	logic [`RSX_DATA_W-1:0]   result;
	logic                     result_wr;
	logic                     cond_true;
	logic [`RSX_DATA_W:0]     diff;
	logic                     fill_bit;

	assign dest_val = regs_reg[DEST_REG];
	assign operand  = USE_IMMEDIATE ? IMMEDIATE_BYTE : regs_reg[SOURCE_REG]; // RQ16

	// circular pointer arithmetic, wraps at depth
	always_comb begin
		sp_dec = (sp_reg == `RSX_SP_RST) ? `RSX_STACK_AW'(`RSX_STACK_DEPTH - 1)
			: sp_reg - `RSX_STACK_AW'(1); // RQ20
		sp_inc = (sp_reg == `RSX_STACK_AW'(`RSX_STACK_DEPTH - 1)) ? `RSX_SP_RST
			: sp_reg + `RSX_STACK_AW'(1); // RQ20
	end

	// return condition test on current flags
	always_comb begin
		unique case (RETURN_COND)
			RSX_COND_ALWAYS:        cond_true = 1'b1; // RQ2
			RSX_COND_CARRY_SET:     cond_true = carry_reg; // RQ2 RQ22
			RSX_COND_CARRY_CLEAR:   cond_true = !carry_reg; // RQ2
			RSX_COND_ZERO_SET:      cond_true = zero_reg; // RQ2
			RSX_COND_IF_ZERO_CLEAR: cond_true = !zero_reg; // RQ2
			default:                cond_true = 1'b0;
		endcase
	end

	// datapath and next-state selection
	always_comb begin
		pc_next    = pc_reg;
		sp_next    = sp_reg;
		carry_next = carry_reg;
		zero_next  = zero_reg;
		result     = dest_val;
		result_wr  = 1'b0;
		fill_bit   = 1'b0;
		diff       = {1'b0, dest_val} - {1'b0, operand};
		if (EXEC_VALID) begin
			pc_next = pc_reg + `RSX_PC_STEP; // RQ21
			unique case (EXEC_OP)
				RSX_OP_NOP: begin
				end
				RSX_OP_CALL: begin
					sp_next = sp_inc;
					pc_next = CALL_TARGET;
				end
				RSX_OP_RETURN: begin
					// flags untouched on either path
					if (cond_true) begin
						pc_next = stack_reg[sp_dec] + `RSX_PC_STEP; // RQ1
						sp_next = sp_dec; // RQ1
					end
					// otherwise stack kept, pc already stepped: RQ3 RQ4
				end
				RSX_OP_ISR_EXIT: begin
					pc_next    = stack_reg[sp_dec]; // RQ5
					sp_next    = sp_dec; // RQ5
					carry_next = ISR_SAVED_CARRY; // RQ6
					zero_next  = ISR_SAVED_ZERO; // RQ6
				end
				RSX_OP_ROTATE_LEFT: begin
					result     = {dest_val[`RSX_MSB-1:0], dest_val[`RSX_MSB]}; // RQ8
					carry_next = dest_val[`RSX_MSB]; // RQ8
					zero_next  = (result == '0); // RQ8
					result_wr  = 1'b1;
				end
				RSX_OP_ROTATE_RIGHT: begin
					result     = {dest_val[`RSX_LSB], dest_val[`RSX_MSB:1]}; // RQ9
					carry_next = dest_val[`RSX_LSB]; // RQ9
					zero_next  = (result == '0); // RQ9
					result_wr  = 1'b1;
				end
				RSX_OP_SHIFT_LEFT_ZERO_FILL,
				RSX_OP_SHIFT_LEFT_ONE_FILL,
				RSX_OP_SHIFT_LEFT_KEEP_LSB,
				RSX_OP_SHIFT_LEFT_CARRY_FILL: begin
					unique case (EXEC_OP)
						RSX_OP_SHIFT_LEFT_ONE_FILL: fill_bit = 1'b1;
						RSX_OP_SHIFT_LEFT_KEEP_LSB: fill_bit = dest_val[`RSX_LSB];
						RSX_OP_SHIFT_LEFT_CARRY_FILL: fill_bit = carry_reg;
						default:                    fill_bit = 1'b0;
					endcase
					result     = {dest_val[`RSX_MSB-1:0], fill_bit}; // RQ10
					carry_next = dest_val[`RSX_MSB]; // RQ10
					zero_next  = (result == '0); // RQ10 RQ11
					result_wr  = 1'b1;
				end
				RSX_OP_SHIFT_RIGHT_ZERO_FILL,
				RSX_OP_SHIFT_RIGHT_ONE_FILL,
				RSX_OP_SHIFT_RIGHT_KEEP_MSB,
				RSX_OP_SHIFT_RIGHT_CARRY_FILL: begin
					unique case (EXEC_OP)
						RSX_OP_SHIFT_RIGHT_ONE_FILL: fill_bit = 1'b1;
						RSX_OP_SHIFT_RIGHT_KEEP_MSB: fill_bit = dest_val[`RSX_MSB];
						RSX_OP_SHIFT_RIGHT_CARRY_FILL: fill_bit = carry_reg;
						default:                     fill_bit = 1'b0;
					endcase
					result     = {fill_bit, dest_val[`RSX_MSB:1]}; // RQ12
					carry_next = dest_val[`RSX_LSB]; // RQ12
					zero_next  = (result == '0); // RQ12 RQ13
					result_wr  = 1'b1;
				end
				RSX_OP_STORE: begin
					// flags held, only scratchpad written: RQ21
				end
				RSX_OP_SUB: begin
					result     = diff[`RSX_DATA_W-1:0]; // RQ17
					carry_next = diff[`RSX_DATA_W]; // RQ18
					zero_next  = (diff[`RSX_DATA_W-1:0] == '0); // RQ19
					result_wr  = 1'b1; // RQ16
				end
				default: begin
				end
			endcase
		end
	end

	// program counter, flags and stack pointer
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pc_reg    <= `RSX_PC_RST;
			sp_reg    <= `RSX_SP_RST; // RQ20
			carry_reg <= 1'b0;
			zero_reg  <= 1'b0;
		end else begin
			pc_reg    <= pc_next;
			sp_reg    <= sp_next;
			carry_reg <= carry_next; // RQ22
			zero_reg  <= zero_next; // RQ22
		end
	end

	// interrupt enable, only changed by interrupt exit here
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ie_reg <= 1'b0;
		end else if (EXEC_VALID && EXEC_OP == RSX_OP_ISR_EXIT) begin
			ie_reg <= ISR_EXIT_ENABLE; // RQ7
		end
	end

	// stack entries, pushed by call
	always_ff @(posedge CORE_CLK) begin
		if (EXEC_VALID && EXEC_OP == RSX_OP_CALL) begin
			stack_reg[sp_reg] <= pc_reg;
		end
	end

	// register file: result write wins over loader port
	always_ff @(posedge CORE_CLK) begin
		if (result_wr) begin
			regs_reg[DEST_REG] <= result; // RQ16
		end else if (REG_WR_EN) begin
			regs_reg[REG_WR_SEL] <= REG_WR_DATA;
		end
	end

	// scratchpad store, upper address bits dropped
	always_ff @(posedge CORE_CLK) begin
		if (EXEC_VALID && EXEC_OP == RSX_OP_STORE) begin
			spad_reg[operand[`RSX_SPAD_AW-1:0]] <= dest_val; // RQ14 RQ15
		end
	end

	// registered observation ports
	always_ff @(posedge CORE_CLK) begin
		REG_RD_DATA  <= regs_reg[REG_RD_SEL];
		SPAD_RD_DATA <= spad_reg[SPAD_RD_ADDR];
	end

	always_comb begin
		PC         = pc_reg;
		CARRY_FLAG = carry_reg;
		ZERO_FLAG  = zero_reg;
		INT_ENABLE = ie_reg;
		STACK_PTR  = sp_reg;
	end
endmodule : rsx_exec

// ---- rtl/rsx_cfg.svh ----
`ifndef RSX_CFG_SVH
`define RSX_CFG_SVH
// data and address widths, register, scratchpad and stack depths
`define RSX_DATA_W      8
`define RSX_PC_W        10
`define RSX_REG_SEL_W   4
`define RSX_NUM_REGS    16
`define RSX_SPAD_AW     6
`define RSX_SPAD_DEPTH  64
`define RSX_STACK_AW    5
`define RSX_STACK_DEPTH 31
// bit positions
`define RSX_MSB         7
`define RSX_LSB         0
// reset values and program counter step
`define RSX_PC_RST      10'h000
`define RSX_SP_RST      5'h00
`define RSX_PC_STEP     10'h001
`endif

// ---- rtl/rsx_pkg.sv ----
package rsx_pkg;
	// operation select presented with EXEC_VALID
	typedef enum logic [4:0] {
		RSX_OP_NOP,
		RSX_OP_RETURN,
		RSX_OP_ISR_EXIT,
		RSX_OP_ROTATE_LEFT,
		RSX_OP_ROTATE_RIGHT,
		RSX_OP_SHIFT_LEFT_ZERO_FILL,
		RSX_OP_SHIFT_LEFT_ONE_FILL,
		RSX_OP_SHIFT_LEFT_KEEP_LSB,
		RSX_OP_SHIFT_LEFT_CARRY_FILL,
		RSX_OP_SHIFT_RIGHT_ZERO_FILL,
		RSX_OP_SHIFT_RIGHT_ONE_FILL,
		RSX_OP_SHIFT_RIGHT_KEEP_MSB,
		RSX_OP_SHIFT_RIGHT_CARRY_FILL,
		RSX_OP_STORE,
		RSX_OP_SUB,
		RSX_OP_CALL
	} rsx_op_t;

	// return conditions
	typedef enum logic [2:0] {
		RSX_COND_ALWAYS,
		RSX_COND_CARRY_SET,
		RSX_COND_CARRY_CLEAR,
		RSX_COND_ZERO_SET,
		RSX_COND_IF_ZERO_CLEAR
	} rsx_cond_t;
endpackage : rsx_pkg

// ---- testbench/rsx_props.sv ----
`timescale 1ns/1ps
module rsx_props (
	input wire logic               CORE_CLK,
	input wire logic               RST,
	input wire logic               EXEC_VALID,
	input wire rsx_pkg::rsx_op_t   EXEC_OP,
	input wire rsx_pkg::rsx_cond_t RETURN_COND,
	input wire logic               ISR_EXIT_ENABLE,
	input wire logic               ISR_SAVED_CARRY,
	input wire logic               ISR_SAVED_ZERO,
	input wire logic [9:0]         PC,
	input wire logic               CARRY_FLAG,
	input wire logic               ZERO_FLAG,
	input wire logic               INT_ENABLE,
	input wire logic [4:0]         STACK_PTR
);
	import rsx_pkg::*;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// issued operations
	sequence s_ret;
		EXEC_VALID && EXEC_OP == RSX_OP_RETURN;
	endsequence
	sequence s_isr;
		EXEC_VALID && EXEC_OP == RSX_OP_ISR_EXIT;
	endsequence
	// flag, stack and pc relations
	property p_ret_flags;
		s_ret |=> $stable(CARRY_FLAG) && $stable(ZERO_FLAG);
	endproperty
	property p_untaken;
		s_ret ##0 (RETURN_COND == RSX_COND_CARRY_SET && !CARRY_FLAG)
			|=> PC == $past(PC) + 10'h001 && $stable(STACK_PTR);
	endproperty
	property p_pop;
		s_isr |=> STACK_PTR == ($past(STACK_PTR) == 5'h00 ? 5'h1e : $past(STACK_PTR) - 5'h01);
	endproperty
	property p_isr_flags;
		s_isr ##1 1'b1 |-> CARRY_FLAG == $past(ISR_SAVED_CARRY) && ZERO_FLAG == $past(ISR_SAVED_ZERO);
	endproperty
	property p_isr_ie;
		s_isr |=> INT_ENABLE == $past(ISR_EXIT_ENABLE);
	endproperty
	property p_sl1;
		EXEC_VALID && EXEC_OP == RSX_OP_SHIFT_LEFT_ONE_FILL |=> !ZERO_FLAG;
	endproperty
	property p_sr1;
		EXEC_VALID && EXEC_OP == RSX_OP_SHIFT_RIGHT_ONE_FILL |=> !ZERO_FLAG;
	endproperty
	property p_store;
		EXEC_VALID && EXEC_OP == RSX_OP_STORE
			|=> $stable({CARRY_FLAG, ZERO_FLAG}) && PC == $past(PC) + 10'h001;
	endproperty
	a_ret_flags: assert property (p_ret_flags) else $error("return changed flags");
	a_untaken: assert property (p_untaken) else $error("untaken return moved");
	a_pop: assert property (p_pop) else $error("stack pointer not popped");
	a_isr_flags: assert property (p_isr_flags) else $error("flags not restored");
	a_isr_ie: assert property (p_isr_ie) else $error("enable form wrong");
	a_sl1: assert property (p_sl1) else $error("zero set by one fill");
	a_sr1: assert property (p_sr1) else $error("zero set by one fill");
	a_store: assert property (p_store) else $error("store touched flags");
endmodule : rsx_props
bind rsx_exec rsx_props u_props (.CORE_CLK(CORE_CLK), .RST(RST), .EXEC_VALID(EXEC_VALID),
	.EXEC_OP(EXEC_OP), .RETURN_COND(RETURN_COND), .ISR_EXIT_ENABLE(ISR_EXIT_ENABLE),
	.ISR_SAVED_CARRY(ISR_SAVED_CARRY), .ISR_SAVED_ZERO(ISR_SAVED_ZERO), .PC(PC),
	.CARRY_FLAG(CARRY_FLAG), .ZERO_FLAG(ZERO_FLAG), .INT_ENABLE(INT_ENABLE),
	.STACK_PTR(STACK_PTR));

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import rsx_pkg::*;
	logic       clk = 1'b0, rst = 1'b1, vld = 1'b0, ie_x = 1'b0, use_imm = 1'b0;
	logic       sav_c = 1'b0, sav_z = 1'b0, we = 1'b0, cf, zf, ie, m_c = 1'b0, m_z = 1'b0;
	logic       m_ie = 1'b0;
	rsx_op_t    op = RSX_OP_NOP;
	rsx_cond_t  cond = RSX_COND_ALWAYS;
	logic [3:0] dst = 4'h0, src = 4'h0, wsel = 4'h0, rsel = 4'h0;
	logic [7:0] imm = 8'h00, wdat = 8'h00, rdat, sdat;
	logic [9:0] tgt = 10'h000, pc;
	logic [5:0] sadr = 6'h00;
	logic [4:0] sp;
	int         m_reg[16], m_spad[64], m_stk[31], m_pc = 0, m_sp = 0, last_a = 0;
	int         mismatches = 0, tests_run = 0, seed = 20649, pend = 0, k;
	always #25 clk = ~clk;
	rsx_exec DUT (.CORE_CLK(clk), .RST(rst), .EXEC_VALID(vld), .EXEC_OP(op),
		.RETURN_COND(cond), .ISR_EXIT_ENABLE(ie_x), .DEST_REG(dst), .SOURCE_REG(src),
		.IMMEDIATE_BYTE(imm), .USE_IMMEDIATE(use_imm), .CALL_TARGET(tgt),
		.ISR_SAVED_CARRY(sav_c), .ISR_SAVED_ZERO(sav_z), .REG_WR_EN(we), .REG_WR_SEL(wsel),
		.REG_WR_DATA(wdat), .REG_RD_SEL(rsel), .SPAD_RD_ADDR(sadr), .PC(pc),
		.CARRY_FLAG(cf), .ZERO_FLAG(zf), .INT_ENABLE(ie), .STACK_PTR(sp),
		.REG_RD_DATA(rdat), .SPAD_RD_DATA(sdat));
	// compare tasks and verdict
	task automatic chk_st();
		tests_run++;
		if ({pc, cf, zf, ie, sp} !== {m_pc[9:0], m_c, m_z, m_ie, m_sp[4:0]}) begin
			mismatches++;
			$display("MISMATCH %0t state pc %h exp %h", $time, pc, m_pc);
		end
	endtask : chk_st
	task automatic chk_dat(input logic [7:0] g, input int e);
		tests_run++;
		if (g !== e[7:0]) begin
			mismatches++;
			$display("MISMATCH %0t data %h exp %h", $time, g, e[7:0]);
		end
	endtask : chk_dat
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// loader write, held for back to back loads
	task automatic ld(input int s, input int v);
		vld <= 1'b0;
		we <= 1'b1;
		wsel <= 4'(s);
		wdat <= 8'(v);
		@(posedge clk);
		m_reg[s] = v;
	endtask : ld
	// read back a register and a scratchpad byte
	task automatic rd(input logic [3:0] s, input logic [5:0] a);
		vld <= 1'b0;
		rsel <= s;
		sadr <= a;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk_dat(rdat, m_reg[s]);
		if (m_spad[a] >= 0) chk_dat(sdat, m_spad[a]);
		@(posedge clk);
	endtask : rd
	// one operation with random fields, then the model step
	task automatic go(input rsx_op_t o);
		int v, w, n, p, f;
		logic [4:0] t;
		op <= o;
		vld <= 1'b1;
		we <= 1'b0;
		{dst, src, imm, use_imm, ie_x, sav_c, sav_z} <= 20'($random(seed));
		cond <= rsx_cond_t'(3'($unsigned($random(seed)) % 5));
		tgt <= 10'($random(seed));
		@(posedge clk);
		v = m_reg[dst];
		w = use_imm ? imm : m_reg[src];
		n = o;
		p = m_pc;
		m_pc = (p + 1) % 1024;
		t = {!m_z, m_z, !m_c, m_c, 1'b1};
		case (o)
			RSX_OP_ROTATE_LEFT, RSX_OP_SHIFT_RIGHT_KEEP_MSB: f = v[7];
			RSX_OP_ROTATE_RIGHT, RSX_OP_SHIFT_LEFT_KEEP_LSB: f = v[0];
			RSX_OP_SHIFT_LEFT_ONE_FILL, RSX_OP_SHIFT_RIGHT_ONE_FILL: f = 1;
			RSX_OP_SHIFT_LEFT_CARRY_FILL, RSX_OP_SHIFT_RIGHT_CARRY_FILL: f = m_c;
			default: f = 0;
		endcase
		if (n == 3 || n inside {[5:8]}) begin
			m_c = v[7];
			m_reg[dst] = (v << 1) % 256 | f;
		end else if (n == 4 || n inside {[9:12]}) begin
			m_c = v[0];
			m_reg[dst] = v >> 1 | f << 7;
		end else if (o == RSX_OP_SUB) begin
			m_c = v < w;
			m_reg[dst] = (v - w + 256) % 256;
		end else if (o == RSX_OP_STORE) begin
			last_a = w % 64;
			m_spad[last_a] = v;
		end else if (o == RSX_OP_CALL) begin
			m_stk[m_sp] = p;
			m_sp = (m_sp + 1) % 31;
			m_pc = tgt;
		end else if (o == RSX_OP_ISR_EXIT || t[cond]) begin
			m_sp = (m_sp + 30) % 31;
			m_pc = (m_stk[m_sp] + (o == RSX_OP_RETURN)) % 1024;
			if (o == RSX_OP_ISR_EXIT) {m_c, m_z, m_ie} = {sav_c, sav_z, ie_x};
		end
		if (n > 2 && n < 13 || n == 14) m_z = m_reg[dst] == 0;
		pend = 1;
	endtask : go
	// state compare after every executed edge
	always @(negedge clk) if (pend) begin
		pend = 0;
		chk_st();
	end
	// watchdog
	initial begin
		#500_000;
		mismatches++;
		close_out();
	end
	// main sequence
	initial begin
		foreach (m_spad[i]) m_spad[i] = -1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk_st();
		$display("test reset done");
		@(posedge clk);
		for (k = 0; k < 16; k++) ld(k, $random(seed) & 255);
		repeat (31) go(RSX_OP_CALL);
		$display("test stack fill done");
		repeat (400) begin
			k = $unsigned($random(seed)) % 15 + 1;
			go(rsx_op_t'(k));
			if (k > 2 && k < 15 && $random(seed) % 3 == 0) rd(dst, 6'(last_a));
		end
		vld <= 1'b0;
		repeat (2) @(posedge clk);
		$display("test random ops done");
		close_out();
	end
endmodule : testbench
